// ===== rtl/tams_pkg.sv
// package for the texture address mode state block
// assumes a single 50 MHz clock domain and an Avalon-MM register slave
package tams_pkg;

    // register byte offsets
    localparam logic [7:0] TAMS_OFS_CTRL      = 8'h00;
    localparam logic [7:0] TAMS_OFS_MODES     = 8'h04;
    localparam logic [7:0] TAMS_OFS_REQ       = 8'h08;
    localparam logic [7:0] TAMS_OFS_STATUS    = 8'h0C;
    localparam logic [7:0] TAMS_OFS_RESULT    = 8'h10;
    localparam logic [7:0] TAMS_OFS_E8_ADDR   = 8'h14;
    localparam logic [7:0] TAMS_OFS_E8_BASE   = 8'h18;
    localparam logic [7:0] TAMS_OFS_E8_DATA   = 8'h1C;
    localparam logic [7:0] TAMS_OFS_E8_INDEX  = 8'h20;

    // field positions in the mode word
    localparam int TAMS_FLD_THIRD_LSB  = 0;
    localparam int TAMS_FLD_SECOND_LSB = 3;
    localparam int TAMS_FLD_FIRST_LSB  = 6;
    localparam int TAMS_FLD_CUBE_LSB   = 9;
    // control word bits
    localparam int TAMS_CTRL_CUBE_SURF = 0;
    localparam int TAMS_CTRL_MONO      = 1;
    localparam int TAMS_CTRL_USE_CUBE  = 2;

    // 8x8 state layout
    localparam int          TAMS_E8_ELEMS     = 16;
    localparam int          TAMS_E8_DWORDS    = 4;
    localparam int          TAMS_E8_SKIP_BIT  = 29;
    localparam int          TAMS_E8_ALIGN_LSB = 5;
    localparam logic [31:0] TAMS_E8_DEF_DW0   = 32'h0000_0000;
    localparam logic [31:0] TAMS_E8_DEF_DW1   = 32'h0000_0000;
    localparam logic [31:0] TAMS_E8_DEF_DW2   = 32'h0D09_0801;
    localparam logic [31:0] TAMS_E8_DEF_DW3   = 32'h721A_03C6;
    localparam logic [31:0] TAMS_BORDER_MONO  = 32'h0000_0000;
    localparam logic [31:0] TAMS_UNMAPPED     = 32'hDEAD_0000;

    typedef enum logic [2:0] {
        addr_mode_repeat         = 3'h0,
        addr_mode_reflect        = 3'h1,
        addr_mode_edge_clamp     = 3'h2,
        addr_mode_cubic          = 3'h3,
        addr_mode_border_fill    = 3'h4,
        addr_mode_reflect_single = 3'h5,
        addr_mode_spare          = 3'h6,
        addr_mode_invalid        = 3'h7
    } tams_mode_e;

    typedef struct packed {
        logic       valid;
        logic       wrap;
        logic       reflect;
        logic       clamp_edge;
        logic       cube_face;
        logic       border;
        logic       reflect_once;
    } tams_dec_s;

    typedef struct packed {
        logic      bad_mode;
        logic      cube_misuse;
        logic      mono_misuse;
        logic      ief_skip;
        logic      edge_neutral;
        logic      ief_detail;
        logic      ief_5x5;
    } tams_stat_s;

    typedef enum logic [1:0] {
        TAMS_IDLE = 2'b00,
        TAMS_RD   = 2'b01,
        TAMS_DONE = 2'b11
    } tams_state_e;

endpackage

// ===== rtl/tams_mode_dec.sv
// decodes one 3-bit coordinate address control code
// assumes purely combinational use inside the state block
`timescale 1ns/100ps
module tams_mode_dec
    import tams_pkg::*;
(
    input  wire logic [2:0] code,
    output tams_dec_s       dec
);
    always_comb
    begin
        dec = '0;
        unique case (code)
            addr_mode_repeat:         dec.wrap         = 1'b1;
            addr_mode_reflect:        dec.reflect      = 1'b1;
            addr_mode_edge_clamp:     dec.clamp_edge   = 1'b1;
            addr_mode_cubic:          dec.cube_face    = 1'b1;
            addr_mode_border_fill:    dec.border       = 1'b1;
            addr_mode_reflect_single: dec.reflect_once = 1'b1;
            default:                  dec.wrap         = 1'b0;
        endcase
        // codes 6 and 7 leave valid low: results undefined
        dec.valid = (code <= 3'h5);
    end
endmodule

// ===== rtl/tams_e8_mem.sv
// memory of 16 elements x 4 dwords of 8x8 sampling state
// assumes one clock; read data registered, one cycle latency
`timescale 1ns/100ps
module tams_e8_mem
    import tams_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        we,
    input  wire logic [5:0]  waddr,
    input  wire logic [31:0] wdata,
    input  wire logic [5:0]  raddr,
    output logic      [31:0] rdata_q
);
    logic [31:0] mem [TAMS_E8_ELEMS*TAMS_E8_DWORDS];

    always_ff @(posedge ref_clk)
    begin
        if (we)
            mem[waddr] <= wdata;
        rdata_q <= mem[raddr];
    end
endmodule

// ===== rtl/tams_top.sv
// texture address mode state decode and 8x8 sampling state store
// assumes Avalon-MM master on ref_clk, synchronous active high reset
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
module tams_top
    import tams_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [2:0]  eff_first_mode_q,
    output logic      [2:0]  eff_second_mode_q,
    output logic      [2:0]  eff_third_mode_q,
    output logic      [31:0] border_sel_q,
    output logic             ief_skip_q,
    output logic             edge_neutral_q
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [11:0] modes_q;
    logic [31:0] border_q;
    logic [31:0] e8_base_q;
    logic [5:0]  e8_addr_q;
    logic [3:0]  e8_index_q;
    logic [15:0] e8_init_q;
    logic [31:0] e8_dw0_q;
    tams_stat_s  stat_q;
    tams_state_e state_q;
    logic [31:0] rd_q;
    logic        wait_q;
    logic [1:0]  fetch_dw_q;

    logic [31:0] wmask;
    logic        acc;
    logic        wr_go;
    logic        rd_go;

    always_comb
    begin
        wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    end
    assign acc   = avs_read | avs_write;
    // request accepted on the edge where waitrequest reads low
    assign wr_go = avs_write & ~wait_q;
    assign rd_go = avs_read & ~wait_q;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic [2:0] first_code;
    logic [2:0] second_code;
    logic [2:0] third_code;
    logic [2:0] cube_code;
    logic       cube_surf;
    logic       mono_on;
    tams_dec_s  dec_first;
    tams_dec_s  dec_second;
    tams_dec_s  dec_third;

    assign cube_surf   = ctrl_q[TAMS_CTRL_CUBE_SURF];
    assign mono_on     = ctrl_q[TAMS_CTRL_MONO];
    assign cube_code   = modes_q[TAMS_FLD_CUBE_LSB +: 3];
    // cube surface control wins for the first component
    assign first_code  = cube_surf ? cube_code : modes_q[TAMS_FLD_FIRST_LSB +: 3];
    assign second_code = modes_q[TAMS_FLD_SECOND_LSB +: 3];
    assign third_code  = modes_q[TAMS_FLD_THIRD_LSB +: 3];

    tams_mode_dec u_dec_first
    (
        .code (first_code),
        .dec  (dec_first)
    );
    tams_mode_dec u_dec_second
    (
        .code (second_code),
        .dec  (dec_second)
    );
    tams_mode_dec u_dec_third
    (
        .code (third_code),
        .dec  (dec_third)
    );

    logic any_bad;
    logic cube_bad;
    logic mono_bad;
    logic is_cube_ok;

    // each component resolves to exactly one handling, except codes 6 and 7, which resolve to none
    assign any_bad  = ~dec_first.valid | ~dec_second.valid | ~dec_third.valid;
    assign is_cube_ok = (dec_first.cube_face | dec_first.clamp_edge)
                      & (first_code == second_code) & (first_code == third_code);
    // flag software errors for cube coordinates, but do not correct them
    assign cube_bad = ctrl_q[TAMS_CTRL_USE_CUBE] & ~is_cube_ok;
    assign mono_bad = mono_on & ~(dec_first.border & dec_second.border & dec_third.border);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            eff_first_mode_q  <= 3'h0;
            eff_second_mode_q <= 3'h0;
            eff_third_mode_q  <= 3'h0;
        end
        else
        begin
            eff_first_mode_q  <= first_code;
            eff_second_mode_q <= second_code;
            eff_third_mode_q  <= third_code;
        end
    end

    // mono filter ignores the programmed border colour
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            border_sel_q <= 32'h0000_0000;
        else
            border_sel_q <= mono_on ? TAMS_BORDER_MONO : border_q;
    end

    // ------------------------------------------------------------
    // 8x8 state memory
    // ------------------------------------------------------------
    logic        mem_we;
    logic [5:0]  mem_raddr;
    logic [31:0] mem_rdata;
    logic [31:0] e8_elem_addr;
    logic [31:0] e8_def;

    assign mem_we    = wr_go && (avs_address == TAMS_OFS_E8_DATA);
    // element stride is four dwords
    assign mem_raddr = (state_q == TAMS_IDLE) ? e8_addr_q
                                              : {e8_index_q, fetch_dw_q};
    assign e8_elem_addr = e8_base_q + {26'h0, e8_index_q, 2'h0} * 32'h4;

    always_comb
    begin
        unique case (mem_raddr[1:0])
            2'h0: e8_def = TAMS_E8_DEF_DW0;
            2'h1: e8_def = TAMS_E8_DEF_DW1;
            2'h2: e8_def = TAMS_E8_DEF_DW2;
            2'h3: e8_def = TAMS_E8_DEF_DW3;
        endcase
    end

    tams_e8_mem u_mem
    (
        .ref_clk (ref_clk),
        .we      (mem_we),
        .waddr   (e8_addr_q),
        .wdata   (avs_writedata),
        .raddr   (mem_raddr),
        .rdata_q (mem_rdata)
    );

    // elements never written read as defaults
    logic       def_sel_q;
    logic [31:0] def_q;
    logic [31:0] e8_word;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            def_sel_q <= 1'b1;
            def_q     <= 32'h0000_0000;
        end
        else
        begin
            def_sel_q <= ~e8_init_q[mem_raddr[5:2]];
            def_q     <= e8_def;
        end
    end
    assign e8_word = def_sel_q ? def_q : mem_rdata;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            e8_init_q <= 16'h0000;
        else if (mem_we && (e8_addr_q[1:0] == 2'h3))
            e8_init_q[e8_addr_q[5:2]] <= 1'b1;
    end

    // ------------------------------------------------------------
    // message fetch: reads dword 0 of the selected element
    // ------------------------------------------------------------
    logic req_go;
    assign req_go = wr_go && (avs_address == TAMS_OFS_REQ);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_q    <= TAMS_IDLE;
            e8_index_q <= 4'h0;
            fetch_dw_q <= 2'h0;
            e8_dw0_q   <= TAMS_E8_DEF_DW0;
        end
        else
        begin
            unique case (state_q)
                TAMS_IDLE:
                begin
                    if (req_go)
                    begin
                        e8_index_q <= avs_writedata[3:0];
                        fetch_dw_q <= 2'h0;
                        state_q    <= TAMS_RD;
                    end
                end
                TAMS_RD:
                    state_q <= TAMS_DONE;
                TAMS_DONE:
                begin
                    e8_dw0_q <= e8_word;
                    state_q  <= TAMS_IDLE;
                end
                default:
                    state_q <= TAMS_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ief_skip_q     <= 1'b0;
            edge_neutral_q <= 1'b0;
        end
        else
        begin
            ief_skip_q     <= e8_dw0_q[TAMS_E8_SKIP_BIT];
            edge_neutral_q <= e8_dw0_q[TAMS_E8_SKIP_BIT];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            stat_q <= '0;
        else
        begin
            stat_q.bad_mode     <= any_bad;
            stat_q.cube_misuse  <= cube_bad;
            stat_q.mono_misuse  <= mono_bad;
            stat_q.ief_skip     <= ief_skip_q;
            stat_q.edge_neutral <= edge_neutral_q;
            // no type or size field remains: fixed detail, 5x5
            stat_q.ief_detail   <= 1'b1;
            stat_q.ief_5x5      <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Avalon slave: one wait cycle per access, reads registered
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            wait_q <= 1'b1;
        else
            wait_q <= ~(acc & wait_q) | ~acc;
    end
    assign avs_waitrequest = wait_q;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctrl_q    <= 32'h0000_0000;
            modes_q   <= 12'h000;
            border_q  <= 32'h0000_0000;
            e8_base_q <= 32'h0000_0000;
            e8_addr_q <= 6'h00;
        end
        else if (wr_go)
        begin
            unique case (avs_address)
                TAMS_OFS_CTRL:
                    ctrl_q <= (ctrl_q & ~wmask) | (avs_writedata & wmask & 32'h0000_0007);
                TAMS_OFS_MODES:
                    modes_q <= (modes_q & ~wmask[11:0]) | (avs_writedata[11:0] & wmask[11:0]);
                TAMS_OFS_RESULT:
                    border_q <= (border_q & ~wmask) | (avs_writedata & wmask);
                TAMS_OFS_E8_BASE:
                    e8_base_q <= {avs_writedata[31:TAMS_E8_ALIGN_LSB], 5'h00};
                TAMS_OFS_E8_ADDR:
                    e8_addr_q <= avs_writedata[5:0];
                TAMS_OFS_E8_DATA:
                    e8_addr_q <= e8_addr_q + 6'h01;
                default:
                    e8_addr_q <= e8_addr_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rd_q <= 32'h0000_0000;
        else if (avs_read & wait_q)
        begin
            unique case (avs_address)
                TAMS_OFS_CTRL:     rd_q <= ctrl_q;
                TAMS_OFS_MODES:    rd_q <= {20'h0, modes_q};
                TAMS_OFS_REQ:      rd_q <= {30'h0, state_q};
                TAMS_OFS_STATUS:   rd_q <= {25'h0, stat_q};
                TAMS_OFS_RESULT:   rd_q <= border_q;
                TAMS_OFS_E8_ADDR:  rd_q <= {26'h0, e8_addr_q};
                TAMS_OFS_E8_BASE:  rd_q <= e8_base_q;
                TAMS_OFS_E8_DATA:  rd_q <= e8_dw0_q;
                TAMS_OFS_E8_INDEX: rd_q <= e8_elem_addr;
                default:           rd_q <= TAMS_UNMAPPED;
            endcase
        end
    end
    assign avs_readdata = rd_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_first_cube_override: assert property (@(posedge ref_clk) disable iff (rst)
        cube_surf |=> eff_first_mode_q == $past(cube_code))
        else $error("first mode not overridden by cube mode");
    a_second_field_pos: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 eff_second_mode_q == $past(modes_q[5:3]))
        else $error("second mode field misplaced");
    a_third_field_pos: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 eff_third_mode_q == $past(modes_q[2:0]))
        else $error("third mode field misplaced");
    a_mono_border_zero: assert property (@(posedge ref_clk) disable iff (rst)
        mono_on |=> border_sel_q == 32'h0000_0000)
        else $error("mono border not zero");
    a_skip_neutral: assert property (@(posedge ref_clk) disable iff (rst)
        ief_skip_q == edge_neutral_q)
        else $error("edge stage not neutral under skip");
    a_fetch_done: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == TAMS_RD) |=> (state_q == TAMS_DONE) ##1 (state_q == TAMS_IDLE))
        else $error("fetch sequence broken");
    a_stride_four: assert property (@(posedge ref_clk) disable iff (rst)
        e8_elem_addr - e8_base_q == {24'h0, e8_index_q, 4'h0})
        else $error("element stride not four dwords");
    a_default_words: assert property (@(posedge ref_clk) disable iff (rst)
        (mem_raddr[1:0] == 2'h3) |=> def_q == 32'h721A_03C6)
        else $error("dword 3 default wrong");
    a_bad_code_seen: assert property (@(posedge ref_clk) disable iff (rst)
        (second_code == 3'h7) |=> stat_q.bad_mode)
        else $error("invalid code not flagged");
    a_fixed_filter: assert property (@(posedge ref_clk) disable iff (rst)
        !rst |=> stat_q.ief_detail && stat_q.ief_5x5)
        else $error("filter not fixed detail 5x5");
endmodule

// ===== testbench/tams_partner.sv
// software and shader-thread stand-in: Avalon-MM master plus state setup
// assumes the slave answers by sampling waitrequest low on a rising edge
`timescale 1ns/100ps
module tams_partner
    import tams_pkg::*;
(
    input  wire logic        ref_clk,
    output logic      [7:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    initial
    begin
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'hF;
    end

    // ------------------------------------------------------------
    // bus cycle
    // ------------------------------------------------------------
    // request held until waitrequest is sampled low; ok stays low on a hang
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        q = 32'h0000_0000;
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        while (n < 64 && ok !== 1'b1)
        begin
            @(posedge ref_clk);
            n++;
            if (avs_waitrequest === 1'b0)
            begin
                ok = 1'b1;
                q = avs_readdata;
            end
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // state setup as software builds it
    // ------------------------------------------------------------
    task automatic set_base(input logic [31:0] b, output logic ok);
        logic [31:0] q;
        access(1'b1, TAMS_OFS_E8_BASE, {b[31:5], 5'h00}, q, ok);
    endtask

    // whole element written, dwords 2 and 3 kept at their defaults
    task automatic put_elem(input logic [3:0] idx, input logic [31:0] dw0, input logic masked,
                            output logic ok);
        logic [31:0] q;
        logic [31:0] v[4];
        logic        k;
        v[0] = dw0 | (32'(masked) << TAMS_E8_SKIP_BIT);
        v[1] = 32'h0000_0000;
        v[2] = TAMS_E8_DEF_DW2;
        v[3] = TAMS_E8_DEF_DW3;
        access(1'b1, TAMS_OFS_E8_ADDR, {26'h0, idx, 2'h0}, q, ok);
        for (int i = 0; i < TAMS_E8_DWORDS; i++)
        begin
            access(1'b1, TAMS_OFS_E8_DATA, v[i], q, k);
            ok = ok & k;
        end
    endtask
endmodule

// ===== testbench/tams_top_tb_top.sv
// self-checking bench for the texture address mode state block
// assumes the partner master drives the register bus; one 50 MHz clock
`timescale 1ns/100ps
module tams_top_tb_top
    import tams_pkg::*;
;
    logic        ref_clk;
    logic        rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  m1;
    logic [2:0]  m2;
    logic [2:0]  m3;
    logic [31:0] border;
    logic        skip;
    logic        neutral;
    int          fails;
    int          n_tests;

    tams_top i_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .eff_first_mode_q(m1),
        .eff_second_mode_q(m2), .eff_third_mode_q(m3), .border_sel_q(border), .ief_skip_q(skip),
        .edge_neutral_q(neutral));

    tams_partner i_part (.ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_mode(input string nm, input logic [2:0] e, input logic [2:0] g);
        chk_word(nm, {29'h0, e}, {29'h0, g});
    endtask

    task automatic chk_flag(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        logic ok;
        i_part.access(w, a, d, q, ok);
        chk_flag("bus answer", 1'b1, ok);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    // fetch walks three states, skip flag lands one cycle after dword 0 is captured
    task automatic settle();
        repeat (6) @(posedge ref_clk);
    endtask

    function automatic logic [31:0] mw(input logic [2:0] k, input logic [2:0] f,
                                       input logic [2:0] s, input logic [2:0] t);
        return (32'(k) << TAMS_FLD_CUBE_LSB) | (32'(f) << TAMS_FLD_FIRST_LSB)
             | (32'(s) << TAMS_FLD_SECOND_LSB) | (32'(t) << TAMS_FLD_THIRD_LSB);
    endfunction

    task automatic give_verdict();
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_codes();
        logic [31:0] q;
        logic [2:0]  f;
        logic [2:0]  s;
        wr(TAMS_OFS_CTRL, 32'h0000_0000);
        for (int c = 0; c < 6; c++)
        begin
            f = 3'((c + 2) % 6);
            s = 3'((c + 1) % 6);
            wr(TAMS_OFS_MODES, mw(3'h0, f, s, 3'(c)));
            settle();
            chk_mode("first mode", f, m1);
            chk_mode("second mode", s, m2);
            chk_mode("third mode", 3'(c), m3);
            xfer(1'b0, TAMS_OFS_STATUS, 32'h0, q);
            chk_flag("bad mode", 1'b0, q[6]);
        end
        wr(TAMS_OFS_MODES, mw(3'h0, 3'h0, 3'h7, 3'h7));
        xfer(1'b0, TAMS_OFS_STATUS, 32'h0, q);
        chk_flag("bad mode", 1'b1, q[6]);
        chk_flag("detail filter", 1'b1, q[1]);
        chk_flag("kernel 5x5", 1'b1, q[0]);
    endtask

    task automatic t_cube();
        logic [31:0] q;
        wr(TAMS_OFS_MODES, mw(3'h3, 3'h0, 3'h3, 3'h3));
        wr(TAMS_OFS_CTRL, 32'h0000_0005);
        settle();
        chk_mode("first on cube", 3'h3, m1);
        chk_mode("second on cube", 3'h3, m2);
        xfer(1'b0, TAMS_OFS_STATUS, 32'h0, q);
        chk_flag("cube misuse", 1'b0, q[5]);
        wr(TAMS_OFS_CTRL, 32'h0000_0004);
        settle();
        chk_mode("first off cube", 3'h0, m1);
        xfer(1'b0, TAMS_OFS_STATUS, 32'h0, q);
        chk_flag("cube misuse", 1'b1, q[5]);
    endtask

    task automatic t_mono();
        logic [31:0] q;
        wr(TAMS_OFS_RESULT, 32'h1234_ABCD);
        wr(TAMS_OFS_CTRL, 32'h0000_0002);
        settle();
        xfer(1'b0, TAMS_OFS_STATUS, 32'h0, q);
        chk_flag("mono misuse", 1'b1, q[4]);
        wr(TAMS_OFS_MODES, mw(3'h0, 3'h4, 3'h4, 3'h4));
        settle();
        chk_word("mono border", TAMS_BORDER_MONO, border);
        xfer(1'b0, TAMS_OFS_STATUS, 32'h0, q);
        chk_flag("mono misuse", 1'b0, q[4]);
        wr(TAMS_OFS_CTRL, 32'h0000_0000);
        settle();
        chk_word("border", 32'h1234_ABCD, border);
    endtask

    task automatic fetch(input logic [3:0] idx, input logic [31:0] e0, input logic es);
        logic [31:0] q;
        wr(TAMS_OFS_REQ, {28'h0, idx});
        settle();
        xfer(1'b0, TAMS_OFS_E8_DATA, 32'h0, q);
        chk_word("fetched dword0", e0, q);
        chk_flag("enhance skip", es, skip);
        chk_flag("edge neutral", es, neutral);
        xfer(1'b0, TAMS_OFS_E8_INDEX, 32'h0, q);
        chk_word("element address", 32'h0000_0040 + 32'(idx) * 32'h10, q);
    endtask

    task automatic t_elems();
        logic ok;
        i_part.set_base(32'h0000_0040, ok);
        chk_flag("base set", 1'b1, ok);
        fetch(4'h3, TAMS_E8_DEF_DW0, 1'b0);
        i_part.put_elem(4'h7, 32'h0000_005A, 1'b1, ok);
        chk_flag("element 7 set", 1'b1, ok);
        i_part.put_elem(4'hF, 32'h0000_0015, 1'b0, ok);
        chk_flag("element 15 set", 1'b1, ok);
        fetch(4'h7, 32'h2000_005A, 1'b1);
        fetch(4'h6, TAMS_E8_DEF_DW0, 1'b0);
        fetch(4'hF, 32'h0000_0015, 1'b0);
        fetch(4'h0, TAMS_E8_DEF_DW0, 1'b0);
    endtask

    task automatic t_unmapped();
        logic [31:0] q;
        wr(TAMS_OFS_CTRL, 32'h0000_0004);
        wr(8'h24, 32'h0000_0003);
        xfer(1'b0, 8'h24, 32'h0, q);
        chk_word("unmapped read", TAMS_UNMAPPED, q);
        xfer(1'b0, TAMS_OFS_CTRL, 32'h0, q);
        chk_word("ctrl kept", 32'h0000_0004, q[31:0] & 32'h0000_0007);
    endtask

    // ------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial
    begin
        fails = 0;
        n_tests = 0;
        rst = 1'b1;
        repeat (20) @(posedge ref_clk);
        chk_flag("wait in reset", 1'b1, avs_waitrequest);
        chk_flag("skip in reset", 1'b0, skip);
        rst <= 1'b0;
        t_codes();
        t_cube();
        t_mono();
        t_elems();
        t_unmapped();
        give_verdict();
    end

    // whole run is a few hundred cycles; this leaves ample margin
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        give_verdict();
    end
endmodule
